// *** hw/fcd_regs.svh ***
// Register decode codes, field positions and reset values of the DMA block
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH

// ----------------------------------------------------------------------
// Host address decode
// ----------------------------------------------------------------------
`define FCD_ADDR_CTRL_BIT 3
`define FCD_FN_STAT_CMD 3'h0
`define FCD_FN_REQUEST 3'h1
`define FCD_FN_ONE_MASK 3'h2
`define FCD_FN_MODE 3'h3
`define FCD_FN_CLR_PTR 3'h4
`define FCD_FN_TEMP_MCLR 3'h5
`define FCD_FN_ALL_MASK 3'h7

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define FCD_CMD_MEM2MEM 0
`define FCD_CMD_COMPRESS 3
`define FCD_REQ_SET_BIT 2
`define FCD_MODE_BLOCK 2'h2
`define FCD_TC_ALL_ONES 16'hffff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FCD_CMD_RST 8'h00
`define FCD_MASK_RST 4'hf
`define FCD_REQ_RST 4'h0
`define FCD_TEMP_RST 8'h00

`endif

// *** hw/fcd_pkg.sv ***
// Types shared by the DMA register and address-generation block
package fcd_pkg;

  // Host register port, sampled on core_clk
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } fcd_host_s;

  // Per-channel setup, stored from data bits 7..2 of a mode write
  typedef struct packed {
    logic [1:0] xfer_mode;
    logic addr_down;
    logic auto_init;
    logic [1:0] xfer_type;
  } fcd_mode_s;

  // Transfer states, Gray coded along the usual walk up to FCD_RD_WR; the return to FCD_IDLE flips two bits
  typedef enum logic [2:0] {
    FCD_IDLE = 3'b000,
    FCD_HI_ADDR = 3'b001,
    FCD_ADDR_CHG = 3'b011,
    FCD_RD_EXT = 3'b010,
    FCD_RD_WR = 3'b110
  } fcd_state_e;

endpackage : fcd_pkg

// *** hw/fcd_chan.sv ***
// One channel: reload and current address and count registers
`timescale 1ns/10ps
module fcd_chan
  import fcd_pkg::*;
(
  input logic core_clk,
  input logic arst_n,
  input logic wr_en,
  input logic wr_cnt,
  input logic wr_hi,
  input logic [7:0] wr_data,
  input logic step,
  input logic step_down,
  input logic reload,
  output logic [15:0] cur_addr,
  output logic [15:0] cur_cnt
);

  logic [15:0] reload_addr_ff;
  logic [15:0] reload_cnt_ff;
  logic [15:0] cur_addr_ff;
  logic [15:0] cur_cnt_ff;

  function automatic logic [15:0] put_byte(input logic [15:0] old,
    input logic hi, input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  // Reload copies change only on host writes; never readable
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reload_addr_ff <= 16'h0000;
      reload_cnt_ff <= 16'h0000;
    end
    else if (wr_en && !wr_cnt)
      reload_addr_ff <= put_byte(reload_addr_ff, wr_hi, wr_data);
    else if (wr_en)
      reload_cnt_ff <= put_byte(reload_cnt_ff, wr_hi, wr_data);
  end

  // Host write overwrites any intermediate value; reload beats a step
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_addr_ff <= 16'h0000;
      cur_cnt_ff <= 16'h0000;
    end
    else if (wr_en && !wr_cnt)
      cur_addr_ff <= put_byte(cur_addr_ff, wr_hi, wr_data);
    else if (wr_en)
      cur_cnt_ff <= put_byte(cur_cnt_ff, wr_hi, wr_data);
    else if (reload)
    begin
      cur_addr_ff <= reload_addr_ff;
      cur_cnt_ff <= reload_cnt_ff;
    end
    else if (step)
    begin
      cur_addr_ff <= step_down ? cur_addr_ff - 16'h0001
                               : cur_addr_ff + 16'h0001;
      cur_cnt_ff <= cur_cnt_ff - 16'h0001; // Zero wraps to all ones
    end
  end

  assign cur_addr = cur_addr_ff;
  assign cur_cnt = cur_cnt_ff;

endmodule : fcd_chan

// *** hw/fcd_addr_seq.sv ***
// Transfer state walk with high-address strobe and address outputs
`timescale 1ns/10ps
module fcd_addr_seq
  import fcd_pkg::*;
(
  input logic core_clk,
  input logic arst_n,
  input logic abort,
  input logic go,
  input logic need_hi,
  input logic compressed,
  input logic [7:0] lo_addr,
  output logic hi_strobe,
  output logic busy,
  output logic [7:0] addr_lo,
  output logic done
);

  fcd_state_e state_ff;
  fcd_state_e nxt_state;
  logic hi_strobe_ff;
  logic busy_ff;
  logic [7:0] addr_lo_ff;
  logic done_ff;

  // Next state; the high-address state is skipped unless asked for
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FCD_IDLE:
        if (go)
          nxt_state = need_hi ? FCD_HI_ADDR : FCD_ADDR_CHG;
      FCD_HI_ADDR: nxt_state = FCD_ADDR_CHG;
      FCD_ADDR_CHG: nxt_state = compressed ? FCD_RD_WR : FCD_RD_EXT;
      FCD_RD_EXT: nxt_state = FCD_RD_WR;
      FCD_RD_WR: nxt_state = FCD_IDLE;
      default: nxt_state = FCD_IDLE;
    endcase
    if (abort)
      nxt_state = FCD_IDLE;
  end

  // State and registered outputs; strobe and busy from the next state, done from the current state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= FCD_IDLE;
      hi_strobe_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      hi_strobe_ff <= (nxt_state == FCD_HI_ADDR);
      busy_ff <= (nxt_state != FCD_IDLE); // Gates the latch onto the bus
      done_ff <= (state_ff == FCD_RD_WR) && !abort;
    end
  end

  // Low address byte driven straight out for the whole transfer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      addr_lo_ff <= 8'h00;
    else if (go && state_ff == FCD_IDLE)
      addr_lo_ff <= lo_addr;
  end

  assign hi_strobe = hi_strobe_ff;
  assign busy = busy_ff;
  assign addr_lo = addr_lo_ff;
  assign done = done_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_short_walk;
    (state_ff == FCD_ADDR_CHG) ##1 (state_ff == FCD_RD_WR)
      ##1 (state_ff == FCD_IDLE);
  endsequence

  chk_compressed_walk: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (go && !need_hi && compressed && !abort && state_ff == FCD_IDLE)
      |=> s_short_walk)
    else $error("compressed transfer not two cycles");

  chk_strobe_pulse: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (go && need_hi && !abort && state_ff == FCD_IDLE)
      |=> hi_strobe ##1 (!hi_strobe && state_ff == FCD_ADDR_CHG))
    else $error("high address strobe not one cycle");

endmodule : fcd_addr_seq

// *** hw/fcd_top.sv ***
// Four-channel DMA programming registers, commands and address generation
`timescale 1ns/10ps
`include "fcd_regs.svh"

// Operation
// - Compressed timing drops the read-extend state
// - High byte on data lines with strobe
// - High-address state when upper byte changes, on a first transfer and after master clear
// - Low address byte driven directly
// - Current address steps after every transfer
// - Count holds words minus one, decrements
// - Terminal count at zero; count then FFFF
// - Host write loads reload and current copies
// - Autoinit restores current copies after end-of-process
// - Sixteen-bit registers accessed as two bytes
// - Eight-bit control register, cleared on reset
// - Mode write, data bits 1..0 choose channel
// - Software request bits set, cleared individually
// - Software request honoured only in block mode
// - Mask blocks hardware requests; set on end-of-process without autoinit
// - Status: terminal flags low, requests high
// - Move buffer keeps last moved byte
// - Master clear acts like hardware reset, except mode and channel registers
// - Pointer clear and master clear ignore data
// - Control address decode when bit 3 high
// - Channel register decode when bit 3 low
module fcd_top
  import fcd_pkg::*;
(
  input logic core_clk,
  input logic arst_n,
  input fcd_host_s host,
  input logic [3:0] channel_request_in,
  input logic xfer_go,
  input logic [1:0] xfer_ch,
  input logic xfer_first,
  input logic end_of_process_in,
  input logic [7:0] move_byte,
  input logic move_byte_vld,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [7:0] addr_lo_out,
  output logic high_address_latch_strobe,
  output logic latch_output_gate,
  output logic terminal_count,
  output logic end_of_process_out,
  output logic xfer_done,
  output logic [3:0] sw_req_grant,
  output logic [3:0] hw_req_open,
  output logic mem_to_mem_start,
  output logic compressed_mode
);

  // ----------------------------------------------------------------------
  // Host access qualification
  // ----------------------------------------------------------------------
  logic rd_prev_ff;
  logic wr_prev_ff;
  logic rd_act;
  logic wr_act;
  logic rd_go;
  logic wr_go;
  logic svc_busy;
  logic [2:0] fn;

  function automatic logic is_ctrl(input logic [3:0] a);
    is_ctrl = a[`FCD_ADDR_CTRL_BIT];
  endfunction : is_ctrl

  // Both strobes low is illegal and counts as no access
  assign rd_act = !host.cs_n && !host.rd_n && host.wr_n;
  assign wr_act = !host.cs_n && !host.wr_n && host.rd_n;
  assign fn = host.addr[2:0];

  // Edge detect so a long strobe counts once
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
    end
    else
    begin
      rd_prev_ff <= rd_act;
      wr_prev_ff <= wr_act;
    end
  end

  assign rd_go = rd_act && !rd_prev_ff;
  // Writes during a service are dropped, the host must wait for idle
  assign wr_go = wr_act && !wr_prev_ff && !svc_busy;

  logic cmd_wr;
  logic req_wr;
  logic one_mask_wr;
  logic mode_wr;
  logic clr_ptr;
  logic mclr;
  logic all_mask_wr;
  logic stat_rd;
  logic temp_rd;
  logic chan_wr;
  logic chan_rd;

  // Control decode uses address alone for the two commands
  assign cmd_wr = wr_go && is_ctrl(host.addr) && fn == `FCD_FN_STAT_CMD;
  assign req_wr = wr_go && is_ctrl(host.addr) && fn == `FCD_FN_REQUEST;
  assign one_mask_wr = wr_go && is_ctrl(host.addr)
                       && fn == `FCD_FN_ONE_MASK;
  assign mode_wr = wr_go && is_ctrl(host.addr) && fn == `FCD_FN_MODE;
  assign clr_ptr = wr_go && is_ctrl(host.addr)
                   && fn == `FCD_FN_CLR_PTR;
  assign mclr = wr_go && is_ctrl(host.addr)
                && fn == `FCD_FN_TEMP_MCLR;
  assign all_mask_wr = wr_go && is_ctrl(host.addr)
                       && fn == `FCD_FN_ALL_MASK;
  assign stat_rd = rd_go && is_ctrl(host.addr) && fn == `FCD_FN_STAT_CMD;
  assign temp_rd = rd_go && is_ctrl(host.addr) && fn == `FCD_FN_TEMP_MCLR;
  assign chan_wr = wr_go && !is_ctrl(host.addr);
  assign chan_rd = rd_go && !is_ctrl(host.addr);

  // ----------------------------------------------------------------------
  // Byte pointer, control and setup registers
  // ----------------------------------------------------------------------
  logic byte_ptr_ff;
  logic [7:0] cmd_ff;
  fcd_mode_s mode_ff [4];
  logic [3:0] req_ff;
  logic [3:0] mask_ff;
  logic [3:0] tc_flags_ff;
  logic [7:0] temp_ff;

  // Low byte first; clearing realigns a host that lost its place
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      byte_ptr_ff <= 1'b0;
    else if (clr_ptr || mclr)
      byte_ptr_ff <= 1'b0;
    else if (chan_wr || chan_rd)
      byte_ptr_ff <= !byte_ptr_ff;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_ff <= `FCD_CMD_RST;
    else if (mclr)
      cmd_ff <= `FCD_CMD_RST;
    else if (cmd_wr)
      cmd_ff <= host.data;
  end

  // Mode survives master clear, like the channel registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      for (int i = 0; i < 4; i++)
        mode_ff[i] <= '0;
    else if (mode_wr)
      mode_ff[host.data[1:0]] <= host.data[7:2];
  end

  // ----------------------------------------------------------------------
  // Transfer service and end of process
  // ----------------------------------------------------------------------
  logic [1:0] act_ch_ff;
  logic [15:0] cur_addr_w [4];
  logic [15:0] cur_cnt_w [4];
  logic seq_done;
  logic seq_strobe;
  logic [7:0] seq_addr_lo;
  logic go_ok;
  logic need_hi;
  logic [7:0] hi_byte_ff;
  logic hi_valid_ff;
  logic [15:0] go_addr;
  logic done_tc;
  logic [3:0] eop_ch;
  logic [3:0] tc_ch;
  logic [3:0] reload_ch;
  logic [3:0] no_ai;

  assign go_ok = xfer_go && !svc_busy && !seq_done && !mclr;
  assign go_addr = cur_addr_w[xfer_ch];
  // Upper byte differs from the last one sent after a carry or borrow across bit 7, a host write or a switch of channel
  assign need_hi = xfer_first || !hi_valid_ff
                   || go_addr[15:8] != hi_byte_ff;
  assign done_tc = seq_done && cur_cnt_w[act_ch_ff] == 16'h0000;
  assign tc_ch = done_tc ? 4'(1 << act_ch_ff) : 4'h0;
  assign eop_ch = (done_tc || end_of_process_in) ? 4'(1 << act_ch_ff)
                                                 : 4'h0;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      act_ch_ff <= 2'h0;
      hi_byte_ff <= 8'h00;
      hi_valid_ff <= 1'b0;
    end
    else if (mclr)
      hi_valid_ff <= 1'b0;
    else if (go_ok)
    begin
      act_ch_ff <= xfer_ch;
      hi_byte_ff <= go_addr[15:8];
      hi_valid_ff <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      assign no_ai[g] = !mode_ff[g].auto_init;
      assign reload_ch[g] = eop_ch[g] && mode_ff[g].auto_init;
      fcd_chan u_chan (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_en(chan_wr && host.addr[2:1] == 2'(g)),
        .wr_cnt(host.addr[0]),
        .wr_hi(byte_ptr_ff),
        .wr_data(host.data),
        .step(seq_done && act_ch_ff == 2'(g)),
        .step_down(mode_ff[g].addr_down),
        .reload(reload_ch[g]),
        .cur_addr(cur_addr_w[g]),
        .cur_cnt(cur_cnt_w[g])
      );
    end
  endgenerate

  fcd_addr_seq u_seq (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .abort(mclr),
    .go(go_ok),
    .need_hi(need_hi),
    .compressed(cmd_ff[`FCD_CMD_COMPRESS]),
    .lo_addr(go_addr[7:0]),
    .hi_strobe(seq_strobe),
    .busy(svc_busy),
    .addr_lo(seq_addr_lo),
    .done(seq_done)
  );

  assign high_address_latch_strobe = seq_strobe;
  assign latch_output_gate = svc_busy;
  assign addr_lo_out = seq_addr_lo;
  assign xfer_done = seq_done;

  // Host write of a request bit wins over a same-cycle end of process
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_ff <= `FCD_REQ_RST;
    else if (mclr)
      req_ff <= `FCD_REQ_RST;
    else
    begin
      req_ff <= req_ff & ~eop_ch;
      if (req_wr)
        req_ff[host.data[1:0]] <= host.data[`FCD_REQ_SET_BIT];
    end
  end

  // Hardware set of a mask bit wins over a host clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_ff <= `FCD_MASK_RST;
    else if (mclr)
      mask_ff <= `FCD_MASK_RST;
    else if (all_mask_wr)
      mask_ff <= host.data[3:0] | (eop_ch & no_ai);
    else if (one_mask_wr)
    begin
      mask_ff <= mask_ff | (eop_ch & no_ai);
      mask_ff[host.data[1:0]] <= host.data[`FCD_REQ_SET_BIT]
        || (eop_ch[host.data[1:0]] && no_ai[host.data[1:0]]);
    end
    else
      mask_ff <= mask_ff | (eop_ch & no_ai);
  end

  // A terminal count in the read cycle survives the clear-on-read
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      tc_flags_ff <= 4'h0;
    else if (mclr)
      tc_flags_ff <= 4'h0;
    else if (stat_rd)
      tc_flags_ff <= tc_ch;
    else
      tc_flags_ff <= tc_flags_ff | tc_ch;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      temp_ff <= `FCD_TEMP_RST;
    else if (mclr)
      temp_ff <= `FCD_TEMP_RST;
    else if (move_byte_vld)
      temp_ff <= move_byte;
  end

  // ----------------------------------------------------------------------
  // Data bus, pulses and request outputs
  // ----------------------------------------------------------------------
  logic [7:0] data_out_ff;
  logic data_oe_ff;
  logic [7:0] rd_data;
  logic [15:0] rd_word;
  logic [3:0] pend;
  logic tc_out_ff;
  logic eop_out_ff;
  logic [3:0] grant_ff;
  logic [3:0] open_ff;
  logic m2m_ff;

  assign pend = channel_request_in | req_ff;
  assign rd_word = host.addr[0] ? cur_cnt_w[host.addr[2:1]]
                                : cur_addr_w[host.addr[2:1]];

  // Only current copies are ever returned to the host
  always_comb
  begin
    rd_data = 8'h00;
    if (!is_ctrl(host.addr))
      rd_data = byte_ptr_ff ? rd_word[15:8] : rd_word[7:0];
    else if (fn == `FCD_FN_STAT_CMD)
      rd_data = {pend, tc_flags_ff};
    else if (fn == `FCD_FN_TEMP_MCLR)
      rd_data = temp_ff;
  end

  // High byte goes out for exactly the strobe cycle; reads hold to end
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_out_ff <= 8'h00;
      data_oe_ff <= 1'b0;
    end
    else if (go_ok && need_hi)
    begin
      data_out_ff <= go_addr[15:8];
      data_oe_ff <= 1'b1;
    end
    else if (chan_rd || stat_rd || temp_rd)
    begin
      data_out_ff <= rd_data;
      data_oe_ff <= 1'b1;
    end
    else
      data_oe_ff <= rd_act && rd_prev_ff && data_oe_ff;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tc_out_ff <= 1'b0;
      eop_out_ff <= 1'b0;
      grant_ff <= 4'h0;
      open_ff <= 4'h0;
      m2m_ff <= 1'b0;
    end
    else
    begin
      tc_out_ff <= done_tc;
      eop_out_ff <= done_tc;
      open_ff <= channel_request_in & ~mask_ff;
      for (int i = 0; i < 4; i++)
        grant_ff[i] <= req_ff[i]
          && mode_ff[i].xfer_mode == `FCD_MODE_BLOCK;
      m2m_ff <= cmd_ff[`FCD_CMD_MEM2MEM] && req_ff[0]
        && mode_ff[0].xfer_mode == `FCD_MODE_BLOCK;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign terminal_count = tc_out_ff;
  assign end_of_process_out = eop_out_ff;
  assign sw_req_grant = grant_ff;
  assign hw_req_open = open_ff;
  assign mem_to_mem_start = m2m_ff;
  assign compressed_mode = cmd_ff[`FCD_CMD_COMPRESS];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_cmd_write: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cmd_wr |=> cmd_ff == $past(host.data))
    else $error("control register not written");

  chk_ptr_toggle: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (chan_wr || chan_rd) && !clr_ptr && !mclr
      |=> byte_ptr_ff != $past(byte_ptr_ff))
    else $error("byte pointer did not toggle");

  chk_mclr_state: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    mclr |=> mask_ff == 4'hf && cmd_ff == 8'h00 && req_ff == 4'h0
      && !byte_ptr_ff && temp_ff == 8'h00 && !svc_busy)
    else $error("master clear incomplete");

  chk_cs_ignore: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    host.cs_n && !move_byte_vld && !seq_done && !end_of_process_in
      |=> $stable(cmd_ff) && $stable(req_ff) && $stable(byte_ptr_ff))
    else $error("deselected access changed state");

  chk_tc_status: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    done_tc && !mclr |=> tc_flags_ff[$past(act_ch_ff)])
    else $error("terminal flag not set");

  chk_count_ones: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    done_tc && no_ai[act_ch_ff] && !chan_wr
      |=> cur_cnt_w[$past(act_ch_ff)] == `FCD_TC_ALL_ONES && tc_out_ff)
    else $error("count not all ones after terminal count");

  chk_eop_mask: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    done_tc && no_ai[act_ch_ff] && !mclr |=> mask_ff[$past(act_ch_ff)])
    else $error("mask not set on end of process");

  chk_stat_clear: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    stat_rd && !done_tc |=> tc_flags_ff == 4'h0)
    else $error("status read did not clear flags");

endmodule : fcd_top

// *** test/fcd_host_model.sv ***
// Host processor model driving the register port
`timescale 1ns/10ps
module fcd_host_model
  import fcd_pkg::*;
(
  input logic core_clk,
  input logic [7:0] data_out,
  output fcd_host_s host
);
  initial host = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h5a};
  // Writes at once without waiting for idle; data flipped on release so stale data is wrong
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host <= '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge core_clk);
    host <= '{1'b1, 1'b1, 1'b1, a, ~d};
  endtask : wr
  // Byte read; sixteen-bit values come as two of these
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    host <= '{1'b0, 1'b0, 1'b1, a, host.data};
    @(posedge core_clk);
    @(posedge core_clk);
    d = data_out;
    host <= '{1'b1, 1'b1, 1'b1, a, ~host.data};
  endtask : rd
endmodule : fcd_host_model

// *** test/fcd_top_test.sv ***
// Self-checking bench for the DMA register and address block
`timescale 1ns/10ps
module fcd_top_test;
  import fcd_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] req_in = 4'h0;
  logic go = 1'b0;
  logic first = 1'b0;
  fcd_host_s host;
  logic [7:0] d_out, a_lo, r;
  logic stb, gate, tc, done, m2m, cmp, oe, eop;
  logic [7:0] mv = 8'h00;
  logic mv_vld = 1'b0;
  logic [3:0] grant, hw_open;
  int n_errors = 0;
  int cmp_count = 0;

  fcd_host_model i_host (.core_clk(core_clk), .data_out(d_out), .host(host));
  fcd_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .host(host),
    .channel_request_in(req_in), .xfer_go(go), .xfer_ch(2'h0),
    .xfer_first(first), .end_of_process_in(1'b0), .move_byte(mv),
    .move_byte_vld(mv_vld), .data_out(d_out), .data_oe(oe),
    .addr_lo_out(a_lo), .high_address_latch_strobe(stb),
    .latch_output_gate(gate), .terminal_count(tc), .end_of_process_out(eop),
    .xfer_done(done), .sw_req_grant(grant), .hw_req_open(hw_open),
    .mem_to_mem_start(m2m), .compressed_mode(cmp));

  // Free-running clock
  always #5 core_clk = ~core_clk;

  // --------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------
  task automatic check(input string w, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", w, e, s);
    end
  endtask : check

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // One transfer on channel 0; a hang counts as a mismatch
  task automatic xfer(input logic f, hs, tce, input logic [7:0] hi, lo,
    input logic [15:0] lat);
    logic [15:0] n;
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    go <= 1'b1;
    first <= f;
    for (n = 0; n < 12 && done !== 1'b1; n++)
    begin
      @(posedge core_clk);
      go <= 1'b0;
      #1;
      if (stb === 1'b1)
      begin
        seen = 1'b1;
        check("high byte", {d_out, gate, oe}, {hi, 2'b11});
      end
    end
    check("low byte", a_lo, lo);
    if (done !== 1'b1)
    begin
      n_errors++;
      summarize();
    end
    check("latency", n, lat);
    check("strobe", seen, hs);
    tick();
    check("tc", {tc, eop}, {tce, tce});
  endtask : xfer

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic reset_values;
    i_host.rd(4'h8, r);
    check("status", r, 8'h00);
    i_host.rd(4'hd, r);
    check("temp", r, 8'h00);
    req_in <= 4'hf;
    tick();
    tick();
    check("open", {hw_open, cmp}, 5'h00);
  endtask : reset_values

  task automatic chan_regs;
    i_host.wr(4'h2, 8'h34);
    i_host.wr(4'hc, 8'hff);
    i_host.wr(4'h2, 8'hcd);
    i_host.wr(4'h2, 8'hab);
    i_host.wr(4'h3, 8'h01);
    i_host.wr(4'h3, 8'h00);
    i_host.rd(4'h2, r);
    check("addr lo", r, 8'hcd);
    i_host.rd(4'h2, r);
    check("addr hi", r, 8'hab);
    i_host.rd(4'h3, r);
    check("cnt lo", r, 8'h01);
  endtask : chan_regs

  task automatic masks_cmds;
    i_host.wr(4'hf, 8'h00);
    i_host.wr(4'ha, 8'h06);
    i_host.wr(4'h8, 8'h08);
    tick();
    tick();
    check("open", {hw_open, cmp}, 5'h17);
    i_host.wr(4'hd, 8'h5a);
    tick();
    tick();
    check("mclr", {hw_open, cmp}, 5'h00);
    req_in <= 4'h0;
  endtask : masks_cmds

  task automatic sw_request;
    i_host.wr(4'hb, 8'h80);
    i_host.wr(4'hb, 8'h41);
    i_host.wr(4'h8, 8'h01);
    i_host.wr(4'h9, 8'h04);
    i_host.wr(4'h9, 8'h05);
    tick();
    check("grant", {grant, m2m}, 5'h03);
    i_host.rd(4'h8, r);
    check("pending", r, 8'h30);
    i_host.wr(4'h9, 8'h00);
    tick();
    check("grant", grant, 4'h0);
  endtask : sw_request

  task automatic transfers;
    i_host.wr(4'hd, 8'h00);
    i_host.wr(4'h0, 8'hff);
    i_host.wr(4'h0, 8'h00);
    i_host.wr(4'h1, 8'h01);
    i_host.wr(4'h1, 8'h00);
    xfer(1'b1, 1'b1, 1'b0, 8'h00, 8'hff, 16'd5);
    xfer(1'b0, 1'b1, 1'b1, 8'h01, 8'h00, 16'd5);
    i_host.rd(4'h1, r);
    check("cnt end", r, 8'hff);
    i_host.rd(4'h8, r);
    check("tc flag", r, 8'h01);
    i_host.wr(4'h8, 8'h08);
    xfer(1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 16'd3);
    // The count read above left the pointer on the high byte
    i_host.wr(4'hc, 8'h00);
    i_host.rd(4'h0, r);
    check("addr", r, 8'h02);
  endtask : transfers

  task automatic move_buffer;
    @(posedge core_clk);
    mv <= 8'hc3;
    mv_vld <= 1'b1;
    @(posedge core_clk);
    mv_vld <= 1'b0;
    mv <= 8'h00;
    i_host.rd(4'hd, r);
    check("temp last", r, 8'hc3);
  endtask : move_buffer

  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    reset_values();
    chan_regs();
    masks_cmds();
    sw_request();
    transfers();
    move_buffer();
    summarize();
  end
endmodule : fcd_top_test
